// ---- core/wdcm_pkg.sv ----
// constants and types shared by the watchdog and clock monitor block
package wdcm_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  ADDR_SVC     = 8'h00;  // service key register
  localparam logic [7:0]  ADDR_CTL     = 8'h01;  // idle tick control and status
  localparam logic [7:0]  SVC_RST      = 8'hd9;  // window 11, key 01100, monitor on
  localparam logic [4:0]  SVC_KEY      = 5'h0c;  // key pattern 01100
  localparam int unsigned KEY_LSB      = 1;
  localparam int unsigned KEY_MSB      = 5;
  localparam int unsigned WIN_LSB      = 6;
  localparam int unsigned WIN_MSB      = 7;
  localparam int unsigned CM_BIT       = 0;
  localparam int unsigned CTL_TAP_MSB  = 2;
  localparam int unsigned CTL_PND_BIT  = 4;
  localparam logic [2:0]  TAP_RST      = 3'h4;

  // ***************************************************************
  // idle timer and service window
  // ***************************************************************
  localparam int unsigned IT_W         = 17;
  localparam int unsigned TAP_BASE     = 12;     // bit 12 toggles every 4k ticks
  localparam int unsigned TAP_NUM      = 5;
  localparam logic [16:0] LOWER_LIM    = 17'h00800;  // 2048 idle ticks
  localparam logic [16:0] UPPER_BASE   = 17'h02000;  // 8k idle ticks, shifted by window

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned HOLD_CYC     = 24;     // inside the 16 to 32 cycle band
  localparam int unsigned CM_LIMIT_US  = 1000;   // slowest accepted edge gap
  localparam int unsigned CM_LIMIT_CYC = CM_LIMIT_US * CLK_MHZ;
  localparam int unsigned CM_W         = 24;

  // fault pin sequencer states
  typedef enum logic [3:0]
  {
    FS_REL  = 4'b0001,
    FS_PULL = 4'b0010,
    FS_HOLD = 4'b0100,
    FS_RISE = 4'b1000
  } wdcm_fault_t;

endpackage : wdcm_pkg

// ---- core/wdcm_tick_if.sv ----
// idle tick carrier between the watchdog core and the idle timer
`timescale 1ns/1ns
interface wdcm_tick_if;
  logic       tick;        // one idle timer clock
  logic [2:0] tap_sel;     // selected pending tap
  logic       tap_toggle;  // selected tap changed this cycle

  modport timer (input tick, input tap_sel, output tap_toggle);
  modport user  (output tick, output tap_sel, input tap_toggle);
endinterface : wdcm_tick_if

// ---- core/wdcm_idle_timer.sv ----
// free running idle counter with selectable pending tap
`timescale 1ns/1ns
module wdcm_idle_timer
  import wdcm_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   pwrup,
  wdcm_tick_if.timer  tk
);

  logic [IT_W-1:0]    cnt_q;
  logic [IT_W-1:0]    cnt_d;
  logic [TAP_NUM-1:0] tap_hit;
  logic [2:0]         sel_c;

  // ***************************************************************
  // counter
  // ***************************************************************
  // power-up clear only: the external reset leaves the count running
  assign cnt_d = pwrup ? '0 : (tk.tick ? cnt_q + IT_W'(1) : cnt_q);

  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_d;
  end

  // ***************************************************************
  // tap toggle detect
  // ***************************************************************
  // a tap toggles when every bit below it carries on this tick
  genvar g;
  generate
    for (g = 0; g < TAP_NUM; g++)
    begin : g_tap
      assign tap_hit[g] = tk.tick & (&cnt_q[TAP_BASE-1+g:0]);
    end
  endgenerate

  // out-of-range selects fall back to the slowest tap
  assign sel_c = (tk.tap_sel > 3'(TAP_NUM-1)) ? 3'(TAP_NUM-1) : tk.tap_sel;
  assign tk.tap_toggle = ~pwrup & tap_hit[sel_c];

endmodule : wdcm_idle_timer

// ---- core/wdcm_top.sv ----
// windowed watchdog with clock monitor and open-drain fault pin
// What this block does
// - option bit 2 low enables watchdog and fault pin with weak pull-up
// - reset inhibits detectors; afterwards max window and monitor enabled
// - first write with key 01100 fixes window and monitor choice for good
// - later writes must match all fields; match restarts, mismatch faults
// - service after the lower limit and before the upper limit, else fault
// - boot entry suppresses lower check and services; return services again
// - on trigger pull pin low, hold 16-32 cycles after it reads low
// - service window restarts when the pin reads high again
// - service writes while the pin is driven are ignored
// - monitor holds pin low while clock is slow, releases 16-32 cycles later
// - clock above 5 kHz never rejected, below 10 Hz always rejected
// - reads of the service register show zero in the key field
// - watchdog timing stops during HALT and IDLE
// - clock monitor keeps running during HALT and IDLE
// - IDLE exit services, HALT exit reloads; software waits 2048 ticks
// - first service after reset is accepted early without lower fault
// - pending flag sets when selected idle tap toggles; software clears
// - idle counter is not cleared by external reset
// - lower window limit is fixed at 2048 idle ticks
// - window bits 7:6 pick 8k, 16k, 32k or 64k upper limit
// - window timing counts idle timer clocks
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module wdcm_top
  import wdcm_pkg::*;
#(
  parameter int unsigned CM_LIMIT = CM_LIMIT_CYC
)
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  PWRUP,
  input  wire logic [wdcm_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [7:0]            RDATA,
  input  wire logic                  OPT_WD_DIS,
  input  wire logic                  IDLE_TICK,
  input  wire logic                  INSTR_CLK,
  input  wire logic                  HALT_MODE,
  input  wire logic                  IDLE_MODE,
  input  wire logic                  BOOT_ROM,
  input  wire logic                  FAULT_PIN_I,
  output logic                       FAULT_PIN_O,
  output logic                       FAULT_PIN_OE_N,
  output logic                       FAULT_PULLUP_EN,
  output logic                       IDLE_TICK_PND
);

  wdcm_tick_if tk ();

  wdcm_fault_t   st_q;
  wdcm_fault_t   st_d;
  logic [7:0]    svc_q;
  logic [7:0]    svc_d;
  logic          first_q;
  logic [16:0]   win_q;
  logic [16:0]   win_d;
  logic [5:0]    hold_q;
  logic [5:0]    hold_d;
  logic [CM_W-1:0] cm_cnt_q;
  logic [CM_W-1:0] cm_cnt_d;
  logic          cm_err_q;
  logic          iclk_q;
  logic          pin_s1_q;
  logic          pin_s2_q;
  logic          halt_q;
  logic          idle_q;
  logic          boot_q;
  logic [2:0]    tap_q;
  logic          pnd_q;
  logic          pnd_d;
  logic [7:0]    rdata_d;
  logic          wd_en;
  logic          cm_en;
  logic          sel_svc;
  logic          sel_ctl;
  logic          svc_wr;
  logic          key_ok;
  logic          all_ok;
  logic          early;
  logic          bad_svc;
  logic          good_svc;
  logic          wd_run;
  logic [16:0]   upper;
  logic          upper_hit;
  logic          wd_err;
  logic          pin_back;
  logic          hw_svc;
  logic          restart;
  logic          iclk_edge;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // ***************************************************************
  // idle timer
  // ***************************************************************
  assign tk.tick    = IDLE_TICK;
  assign tk.tap_sel = tap_q;

  wdcm_idle_timer u_idle_timer
  (
    .clk   (CLK_SYS),
    .pwrup (PWRUP),
    .tk    (tk)
  );

  // ***************************************************************
  // decode and service checks
  // ***************************************************************
  // enable from option bit
  assign wd_en   = ~OPT_WD_DIS;
  assign cm_en   = wd_en & svc_q[CM_BIT];
  assign sel_svc = (ADDR == ADDR_SVC);
  assign sel_ctl = (ADDR == ADDR_CTL);
  // writes only count while the pin is released
  assign svc_wr  = WR & sel_svc & wd_en & (st_q == FS_REL);
  assign key_ok  = (WDATA[KEY_MSB:KEY_LSB] == SVC_KEY);
  // every field compared after the first write
  assign all_ok  = key_ok & (WDATA == svc_q);
  // lower limit, suppressed in boot and before first service
  assign early   = first_q & ~boot_q & (win_q < LOWER_LIM);
  // first write needs only the key
  assign good_svc = svc_wr & (first_q ? all_ok : key_ok) & ~early;
  assign bad_svc  = svc_wr & ~good_svc;

  assign upper = UPPER_BASE << svc_q[WIN_MSB:WIN_LSB];
  // timing stops in low power modes and while faulted
  assign wd_run    = wd_en & ~HALT_MODE & ~IDLE_MODE & (st_q == FS_REL);
  assign upper_hit = wd_run & IDLE_TICK & (win_q == upper - 17'h00001);
  assign wd_err    = upper_hit | bad_svc;

  assign pin_back = (st_q == FS_RISE) & pin_s2_q;
  // boot entry and exit service; IDLE and HALT exit
  assign hw_svc   = (BOOT_ROM ^ boot_q) | (idle_q & ~IDLE_MODE) | (halt_q & ~HALT_MODE);
  assign restart  = good_svc | pin_back | hw_svc | ~wd_en;

  // ***************************************************************
  // service register and window counter
  // ***************************************************************
  // only the first accepted write changes the stored choices
  assign svc_d = (good_svc & ~first_q) ? WDATA : svc_q;
  // counts idle timer clocks; restart on return high
  assign win_d = restart ? 17'h00000 :
                 ((wd_run & IDLE_TICK) ? win_q + 17'h00001 : win_q);

  // reset value arms maximum window with monitor on
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      svc_q   <= SVC_RST;
      first_q <= 1'b0;
      win_q   <= '0;
    end
    else
    begin
      svc_q   <= svc_d;
      first_q <= first_q | good_svc;
      win_q   <= win_d;
    end
  end

  // ***************************************************************
  // clock monitor
  // ***************************************************************
  // the edge gap limit sits between 100 us and 50 ms so both bounds hold
  assign iclk_edge = INSTR_CLK ^ iclk_q;
  assign cm_cnt_d  = (iclk_edge | ~cm_en) ? '0 :
                     ((cm_cnt_q >= CM_W'(CM_LIMIT)) ? cm_cnt_q : cm_cnt_q + CM_W'(1));

  // reject when no edge inside the limit
  // runs regardless of HALT and IDLE
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      iclk_q   <= 1'b0;
      cm_cnt_q <= '0;
      cm_err_q <= 1'b0;
    end
    else
    begin
      iclk_q   <= INSTR_CLK;
      cm_cnt_q <= cm_cnt_d;
      cm_err_q <= cm_en & (cm_cnt_d >= CM_W'(CM_LIMIT));
    end
  end

  // ***************************************************************
  // fault pin sequencer
  // ***************************************************************
  always_comb
  begin
    st_d   = st_q;
    hold_d = hold_q;
    case (st_q)
      FS_REL:
        if (wd_err | cm_err_q)
          st_d = FS_PULL;
      // wait for the sensed pin to fall
      FS_PULL:
      begin
        hold_d = '0;
        if (~pin_s2_q)
          st_d = FS_HOLD;
      end
      // a slow clock keeps restarting the hold
      FS_HOLD:
        if (cm_err_q)
          hold_d = '0;
        else if (hold_q == 6'(HOLD_CYC - 1))
          st_d = FS_RISE;
        else
          hold_d = hold_q + 6'h01;
      FS_RISE:
        if (cm_err_q)
          st_d = FS_PULL;
        else if (pin_s2_q)
          st_d = FS_REL;
      default:
        st_d = FS_REL;
    endcase
    if (~wd_en)
      st_d = FS_REL;
  end

  // two-flop pin sense; drive while pulling or holding
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st_q            <= FS_REL;
      hold_q          <= '0;
      pin_s1_q        <= 1'b1;
      pin_s2_q        <= 1'b1;
      FAULT_PIN_O     <= 1'b0;
      FAULT_PIN_OE_N  <= 1'b1;
      FAULT_PULLUP_EN <= 1'b0;
    end
    else
    begin
      st_q            <= st_d;
      hold_q          <= hold_d;
      pin_s1_q        <= FAULT_PIN_I;
      pin_s2_q        <= pin_s1_q;
      FAULT_PIN_O     <= 1'b0;
      FAULT_PIN_OE_N  <= ~((st_d == FS_PULL) | (st_d == FS_HOLD));
      FAULT_PULLUP_EN <= wd_en;
    end
  end

  // ***************************************************************
  // mode tracking, pending flag and read port
  // ***************************************************************
  // set wins over a same-cycle write-one clear
  assign pnd_d = tk.tap_toggle |
                 (pnd_q & ~(WR & sel_ctl & WDATA[CTL_PND_BIT]));
  assign rdata_d = ~RD ? 8'h00 :
                   sel_svc ? {svc_q[WIN_MSB:WIN_LSB], 5'h00, svc_q[CM_BIT]} :
                   sel_ctl ? {~FAULT_PIN_OE_N, cm_err_q, first_q, pnd_q, 1'b0, tap_q} :
                   8'h00;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      halt_q        <= 1'b0;
      idle_q        <= 1'b0;
      boot_q        <= 1'b0;
      tap_q         <= TAP_RST;
      pnd_q         <= 1'b0;
      IDLE_TICK_PND <= 1'b0;
      RDATA         <= 8'h00;
    end
    else
    begin
      halt_q        <= HALT_MODE;
      idle_q        <= IDLE_MODE;
      boot_q        <= BOOT_ROM;
      tap_q         <= (WR & sel_ctl) ? WDATA[CTL_TAP_MSB:0] : tap_q;
      pnd_q         <= pnd_d;
      IDLE_TICK_PND <= pnd_d;
      RDATA         <= rdata_d;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  a_bad_key_pulls: assert property (
    svc_wr & ~key_ok |=> st_q == FS_PULL) else $error("bad key did not fault");
  a_early_service: assert property (
    svc_wr & early |=> st_q == FS_PULL) else $error("early service not flagged");
  a_upper_expiry: assert property (
    wd_run & IDLE_TICK & win_q == upper - 17'h00001 |=> !FAULT_PIN_OE_N)
    else $error("upper limit expiry not driven");
  a_choice_frozen: assert property (
    first_q |=> $stable(svc_q)) else $error("service choices changed after first write");
  a_hold_length: assert property (
    $rose(st_q == FS_RISE) |-> $past(st_q == FS_HOLD, HOLD_CYC))
    else $error("hold phase length wrong");
  a_ignore_faulted: assert property (
    WR & sel_svc & st_q != FS_REL |=> $stable(svc_q) && $stable(first_q))
    else $error("service taken while faulted");
  a_key_read_zero: assert property (
    RD & sel_svc |=> RDATA[5:1] == 5'h00) else $error("key field visible on read");
  a_return_restart: assert property (
    st_q == FS_RISE && pin_s2_q && !cm_err_q |=> win_q == 17'h00000)
    else $error("window not restarted on pin return");
  a_low_power_stop: assert property (
    HALT_MODE && $past(HALT_MODE) && !restart |=> $stable(win_q))
    else $error("window counted in low power");
  a_monitor_drive: assert property (
    cm_err_q && st_q == FS_REL |=> !FAULT_PIN_OE_N) else $error("slow clock not driven");
  a_pend_set_wins: assert property (
    tk.tap_toggle |=> IDLE_TICK_PND) else $error("pending flag lost");
  // hardware services clear the window, a disabled block leaves the pin alone
  a_idle_exit_svc: assert property (
    idle_q && !IDLE_MODE |=> win_q == 17'h00000) else $error("no service on idle exit");
  a_boot_entry_svc: assert property (
    BOOT_ROM && !boot_q |=> win_q == 17'h00000) else $error("no service on boot entry");
  a_disabled_quiet: assert property (
    OPT_WD_DIS |=> FAULT_PIN_OE_N && !FAULT_PULLUP_EN) else $error("disabled block drives pin");

  c_good_service:  cover property (svc_wr && good_svc && first_q);
  c_full_fault:    cover property ($rose(st_q == FS_RISE) ##[1:20] st_q == FS_REL);
  c_monitor_error: cover property ($rose(cm_err_q));
  c_idle_exit:     cover property (idle_q && !IDLE_MODE);
  c_boot_service:  cover property (svc_wr && good_svc && boot_q);

endmodule : wdcm_top

// ---- verif/wdcm_pin_model.sv ----
// external reset circuit view of the open-drain fault pin with weak pull-up
`timescale 1ns/1ns
module wdcm_pin_model
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic oe_n,
  input  wire logic pullup_en,
  input  wire logic slow,
  output logic      pin
);
  logic [3:0] rise_q;
  logic       flt_q;

  // ***************************************************************
  // pin resolution
  // ***************************************************************
  // cycles since release; a heavy load lets the weak pull-up rise late
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rise_q <= 4'h0;
      flt_q  <= 1'b0;
    end
    else
    begin
      rise_q <= !oe_n ? 4'h0 : (rise_q == 4'hf ? rise_q : rise_q + 4'h1);
      flt_q  <= ~flt_q;
    end
  end

  // weak pull-up release
  // a floating pin toggles so that no stale level can pass for a real one
  assign pin = !oe_n ? 1'b0 : !pullup_en ? flt_q : (slow && rise_q < 4'h8) ? 1'b0 : 1'b1;
endmodule : wdcm_pin_model

// ---- verif/testbench.sv ----
// self-checking bench for the watchdog and clock monitor block
`timescale 1ns/1ns
module testbench;
  import wdcm_pkg::*;
  logic       CLK_SYS = 1'b0, RST = 1'b1, PWRUP = 1'b0, WR = 1'b0, RD = 1'b0;
  logic       OPT_WD_DIS = 1'b0, IDLE_TICK = 1'b0, INSTR_CLK = 1'b0;
  logic       HALT_MODE = 1'b0, BOOT_ROM = 1'b0, slow = 1'b0, cstop = 1'b0, IDLE_MODE = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
  logic       FAULT_PIN_I, FAULT_PIN_O, FAULT_PIN_OE_N, FAULT_PULLUP_EN, IDLE_TICK_PND;
  int         errors = 0, n_checks = 0, cyc = 0;

  wdcm_top #(.CM_LIMIT(200)) u_wdcm_top (.CLK_SYS(CLK_SYS), .RST(RST), .PWRUP(PWRUP),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OPT_WD_DIS(OPT_WD_DIS),
    .IDLE_TICK(IDLE_TICK), .INSTR_CLK(INSTR_CLK), .HALT_MODE(HALT_MODE),
    .IDLE_MODE(IDLE_MODE),
    .BOOT_ROM(BOOT_ROM), .FAULT_PIN_I(FAULT_PIN_I), .FAULT_PIN_O(FAULT_PIN_O),
    .FAULT_PIN_OE_N(FAULT_PIN_OE_N), .FAULT_PULLUP_EN(FAULT_PULLUP_EN),
    .IDLE_TICK_PND(IDLE_TICK_PND));
  wdcm_pin_model u_wdcm_pin_model (.clk(CLK_SYS), .rst(RST), .oe_n(FAULT_PIN_OE_N),
    .pullup_en(FAULT_PULLUP_EN), .slow(slow), .pin(FAULT_PIN_I));

  // ***************************************************************
  // clocks, idle ticks and hang guard
  // ***************************************************************
  // 50 MHz system clock
  always #10 CLK_SYS = ~CLK_SYS;
  // idle tick every other cycle keeps windows short; instruction clock can stall
  always @(posedge CLK_SYS)
  begin
    IDLE_TICK <= ~IDLE_TICK;
    INSTR_CLK <= cstop ? INSTR_CLK : ~INSTR_CLK;
    cyc++;
    if (cyc == 70000)
    begin
      errors++;
      $display("wrong value at %0t ns: run did not finish", $time);
      conclude();
    end
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd

  // pin drive must stay at level v for n cycles
  task automatic hold(input logic v, input int n, input string msg);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge CLK_SYS);
      #1;
      if (FAULT_PIN_OE_N !== v)
        bad = 1'b1;
    end
    chk(bad, 1'b0, msg);
  endtask : hold

  task automatic wait_oe(input logic v, input int lim, input string msg);
    int i;
    i = 0;
    #1;
    while (FAULT_PIN_OE_N !== v && i < lim)
    begin
      @(posedge CLK_SYS);
      #1;
      i++;
    end
    chk(FAULT_PIN_OE_N, v, msg);
  endtask : wait_oe

  // one watchdog fault: pull, bounded hold, release, pin back high
  task automatic fault(input int lim, input string msg);
    int n;
    n = 0;
    wait_oe(1'b0, lim, msg);
    chk(FAULT_PIN_O, 1'b0, "pin driven low");
    while (FAULT_PIN_OE_N === 1'b0 && n < 100)
    begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    chk(n >= 16 && n <= 32, 1'b1, "hold after pin low");
    if (slow)
      wr(ADDR_SVC, 8'hff);
    n = 0;
    while (FAULT_PIN_I !== 1'b1 && n < 50)
    begin
      @(posedge CLK_SYS);
      n++;
    end
  endtask : fault

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial
  begin
    @(posedge CLK_SYS);
    PWRUP <= 1'b1;
    @(posedge CLK_SYS);
    PWRUP <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(FAULT_PULLUP_EN, 1'b1, "pull-up after reset");
    chk(FAULT_PIN_OE_N, 1'b1, "pin idle after reset");
    rd(ADDR_SVC, d);
    chk(d, 8'hc1, "service reset value");
    rd(8'h05, d);
    chk(d, 8'h00, "unmapped read");
    $display("test reset finished");
    wr(ADDR_SVC, 8'h19);
    hold(1'b1, 50, "early first service");
    rd(ADDR_SVC, d);
    chk(d, 8'h01, "stored window and monitor");
    wr(ADDR_CTL, 8'h10);
    wr(ADDR_SVC, 8'h19);
    fault(4, "service below lower limit");
    $display("test first service finished");
    slow = 1'b1;
    hold(1'b1, 4200, "quiet after fault");
    wr(ADDR_SVC, 8'h19);
    hold(1'b1, 20, "valid service");
    for (int k = 0; k < 3; k++)
    begin
      hold(1'b1, 4200, "ignored write or restart");
      wr(ADDR_SVC, k == 0 ? 8'h59 : k == 1 ? 8'h1d : 8'h18);
      fault(4, "field mismatch");
    end
    hold(1'b1, 4200, "quiet after fault");
    wr(ADDR_SVC, 8'h19);
    $display("test mismatches finished");
    slow = 1'b0;
    hold(1'b1, 16000, "inside upper limit");
    rd(ADDR_CTL, d);
    chk(d & 8'h17, 8'h10, "pending set, tap 0");
    chk(IDLE_TICK_PND, 1'b1, "pending pin");
    wr(ADDR_CTL, 8'h10);
    @(posedge CLK_SYS);
    #1;
    chk(IDLE_TICK_PND, 1'b0, "pending cleared");
    fault(600, "upper limit expiry");
    $display("test upper limit finished");
    BOOT_ROM <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    wr(ADDR_SVC, 8'h19);
    hold(1'b1, 30, "boot suppresses lower check");
    BOOT_ROM <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    wr(ADDR_SVC, 8'h19);
    fault(4, "lower check back after boot");
    $display("test boot finished");
    hold(1'b1, 4200, "quiet after fault");
    wr(ADDR_SVC, 8'h19);
    HALT_MODE <= 1'b1;
    hold(1'b1, 17000, "watchdog stopped in halt");
    HALT_MODE <= 1'b0;
    wr(ADDR_SVC, 8'h19);
    fault(4, "service too soon after halt");
    @(posedge CLK_SYS);
    IDLE_MODE <= 1'b1;
    hold(1'b1, 50, "watchdog stopped in idle");
    @(posedge CLK_SYS);
    IDLE_MODE <= 1'b0;
    wr(ADDR_SVC, 8'h19);
    fault(4, "service too soon after idle");
    $display("test halt finished");
    HALT_MODE <= 1'b1;
    cstop = 1'b1;
    hold(1'b1, 150, "monitor tolerates short gap");
    wait_oe(1'b0, 100, "monitor trips in halt");
    hold(1'b0, 300, "monitor holds pin");
    cstop = 1'b0;
    HALT_MODE <= 1'b0;
    wait_oe(1'b1, 60, "monitor releases");
    $display("test monitor finished");
    OPT_WD_DIS <= 1'b1;
    RST        <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    #1;
    chk(FAULT_PULLUP_EN, 1'b0, "disabled pin");
    chk(FAULT_PIN_OE_N, 1'b1, "disabled drive");
    wr(ADDR_SVC, 8'h00);
    hold(1'b1, 10, "disabled ignores bad service");
    $display("test disable finished");
    conclude();
  end
endmodule : testbench
